// ### hdl/cpsc_top.sv
/*
 card power serial control front end: serial word shift, latch, decode to
 per-slot supply switch enables, asynchronous reset and shutdown, overcurrent
 flag, plus an avalon-mm register slave with a level interrupt.
 assumes ref_clk at 100 mhz, the serial clock far slower (80 ns period),
 and analogue comparators giving one overcurrent level per output.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cpsc_defs.svh"

module cpsc_top #(
   parameter logic [3:0][2:0] MAIN_MAP = {3'h0, 3'h4, 3'h2, 3'h1},
   parameter logic [7:0][3:0] AUX_MAP = {16'h0000, 16'h8421}
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic serial_clk_in,
   input wire logic serial_data_in,
   input wire logic serial_latch_in,
   input wire logic serial_latch_driven,
   input wire logic reset_n_input,
   input wire logic shutdown_n_input,
   input wire logic [3:0] overcurrent_sense,
   output logic [2:0] slot_a_main_supply_out,
   output logic [3:0] slot_a_aux_supply_out,
   output logic [2:0] slot_b_main_supply_out,
   output logic [3:0] slot_b_aux_supply_out,
   output logic [3:0] current_limit,
   output logic overcurrent_flag_n_out,
   output logic overcurrent_flag_n_oe,
   input wire logic [`CPSC_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq
);

   // input synchronisers, a change counts once stages two and three agree
   wire logic latch_eff;
   wire logic [`CPSC_SYNC_N-1:0] raw_in;
   logic [`CPSC_SYNC_N-1:0] filt;
   logic [`CPSC_SYNC_N-1:0] filt_d;

   // pull-down: a floating latch pad is seen as low
   assign latch_eff = serial_latch_in & serial_latch_driven;
   assign raw_in = {overcurrent_sense, reset_n_input, shutdown_n_input, latch_eff,
                    serial_data_in, serial_clk_in};

   // idle levels of the pins, so no false edge follows reset
   localparam logic [`CPSC_SYNC_N-1:0] SYNC_INIT = `CPSC_SYNC_INIT;

   genvar gi;
   generate
      for (gi = 0; gi < `CPSC_SYNC_N; gi++) begin : g_sync
         logic s1;
         logic s2;
         logic s3;
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               s1 <= SYNC_INIT[gi];
               s2 <= SYNC_INIT[gi];
               s3 <= SYNC_INIT[gi];
               filt[gi] <= SYNC_INIT[gi];
               filt_d[gi] <= SYNC_INIT[gi];
            end else begin
               s1 <= raw_in[gi];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3) begin
                  filt[gi] <= s3;
               end
               filt_d[gi] <= filt[gi];
            end
         end
      end
   endgenerate

   wire logic sclk_rise;
   wire logic sdata_f;
   wire logic latch_rise;
   wire logic [3:0] overcurrent_f;
   wire logic [3:0] overcurrent_rise;
   wire logic shutdown_fall;
   wire logic rst_fall;
   assign sclk_rise = filt[`CPSC_IN_SCLK] & ~filt_d[`CPSC_IN_SCLK];
   assign sdata_f = filt[`CPSC_IN_SDATA];
   assign latch_rise = filt[`CPSC_IN_LATCH] & ~filt_d[`CPSC_IN_LATCH];
   assign overcurrent_f = filt[`CPSC_IN_OVC_LSB +: 4];
   assign overcurrent_rise = overcurrent_f & ~filt_d[`CPSC_IN_OVC_LSB +: 4];
   assign shutdown_fall = ~filt[`CPSC_IN_SHUTDOWN_N] & filt_d[`CPSC_IN_SHUTDOWN_N];
   assign rst_fall = ~filt[`CPSC_IN_RST_N] & filt_d[`CPSC_IN_RST_N];

   // shift and holding registers; the reset pin loads 11'h100 into them as well
   wire logic force_off;
   wire logic force_hiz;
   assign force_off = rst | ~reset_n_input;
   assign force_hiz = ~shutdown_n_input;

   cpsc_pkg::cpsc_word_t shift_reg;
   cpsc_pkg::cpsc_word_t hold_q;
   wire cpsc_pkg::cpsc_word_t next_shift;
   wire logic [`CPSC_WORD_W-2:0] shift_upper;
   // D0 enters first and ends in bit 0 after eleven clocks
   assign shift_upper = shift_reg[`CPSC_WORD_W-1:1];
   assign next_shift = {sdata_f, shift_upper};

   always_ff @(posedge ref_clk or posedge force_off) begin
      if (force_off) begin
         shift_reg <= `CPSC_WORD_RST;
      end else if (sclk_rise) begin
         shift_reg <= next_shift;
      end
   end

   // a latch edge that lands with a clock edge still sees the old shift
   // contents; the controller keeps the two apart
   always_ff @(posedge ref_clk or posedge force_off) begin
      if (force_off) begin
         hold_q <= `CPSC_WORD_RST;
      end else if (latch_rise) begin
         hold_q <= shift_reg;
      end
   end

   // decode through the parameter tables
   wire logic [1:0][1:0] main_code;
   wire logic [1:0][2:0] aux_code;
   wire logic word_on;
   wire cpsc_pkg::cpsc_main_sw_t [1:0] next_main;
   wire cpsc_pkg::cpsc_aux_sw_t [1:0] next_aux;
   assign main_code[0] = hold_q[`CPSC_A_MAIN_LSB +: 2];
   assign main_code[1] = hold_q[`CPSC_B_MAIN_LSB +: 2];
   assign aux_code[0] = hold_q[`CPSC_A_AUX_LSB +: 3];
   assign aux_code[1] = {hold_q[`CPSC_B_AUX_HI_LSB +: 2], hold_q[`CPSC_B_AUX_LO]};
   assign word_on = hold_q[`CPSC_SHUTDOWN_BIT];

   generate
      for (gi = 0; gi < 2; gi++) begin : g_slot
         assign next_main[gi] = word_on ? MAIN_MAP[main_code[gi]] : 3'h0;
         assign next_aux[gi] = word_on ? AUX_MAP[aux_code[gi]] : 4'h0;
      end
   endgenerate

   // switch enables; reset wins over shutdown, both act without the clock
   cpsc_pkg::cpsc_main_sw_t [1:0] main_q;
   cpsc_pkg::cpsc_aux_sw_t [1:0] aux_q;
   always_ff @(posedge ref_clk or posedge force_off or posedge force_hiz) begin
      if (force_off) begin
         main_q <= {`CPSC_MAIN_OFF, `CPSC_MAIN_OFF};
         aux_q <= {`CPSC_AUX_OFF, `CPSC_AUX_OFF};
      end else if (force_hiz) begin
         main_q <= '0;
         aux_q <= '0;
      end else begin
         main_q <= next_main;
         aux_q <= next_aux;
      end
   end
   assign slot_a_main_supply_out = main_q[0];
   assign slot_b_main_supply_out = main_q[1];
   assign slot_a_aux_supply_out = aux_q[0];
   assign slot_b_aux_supply_out = aux_q[1];

   // overcurrent: each output limited on its own, one shared flag
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         current_limit <= 4'h0;
         overcurrent_flag_n_out <= 1'b0;
         overcurrent_flag_n_oe <= 1'b0;
      end else begin
         current_limit <= overcurrent_f;
         overcurrent_flag_n_out <= 1'b0;
         overcurrent_flag_n_oe <= |overcurrent_f;
      end
   end

   // avalon-mm slave: one wait state, then the transfer completes
   logic wait_q;
   logic [`CPSC_STAT_W-1:0] mask_q;
   cpsc_pkg::cpsc_stat_t status_q;
   wire logic req;
   wire logic take;
   wire logic sel_status;
   wire logic sel_mask;
   wire logic sel_word;
   wire logic sel_outs;
   wire logic [31:0] rd_mux;
   wire cpsc_pkg::cpsc_stat_t stat_set;
   wire cpsc_pkg::cpsc_stat_t stat_clr;
   wire cpsc_pkg::cpsc_stat_t next_status;

   assign req = avs_read | avs_write;
   assign take = req & ~wait_q;
   assign sel_status = avs_address == `CPSC_REG_STATUS;
   assign sel_mask = avs_address == `CPSC_REG_MASK;
   assign sel_word = avs_address == `CPSC_REG_WORD;
   assign sel_outs = avs_address == `CPSC_REG_OUTS;
   // unmapped addresses read zero and ignore writes
   assign rd_mux = sel_status ? {25'h0, status_q} :
                   sel_mask ? {25'h0, mask_q} :
                   sel_word ? {5'h0, shift_reg, 5'h0, hold_q} :
                   sel_outs ? {12'h0, overcurrent_f, 1'b0, aux_q[1], main_q[1], 1'b0,
                               aux_q[0], main_q[0]} : 32'h0;

   assign stat_set = {rst_fall, shutdown_fall, latch_rise, overcurrent_rise};
   // only bits that were returned are cleared, so a late event survives
   assign stat_clr = (take & avs_read & sel_status) ?
                     avs_readdata[`CPSC_STAT_W-1:0] : 7'h00;
   assign next_status = (status_q & ~stat_clr) | stat_set;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wait_q <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         wait_q <= ~(req & wait_q);
         if (req & wait_q) begin
            avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
         end
      end
   end
   assign avs_waitrequest = wait_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mask_q <= `CPSC_MASK_RST;
         status_q <= '0;
         irq <= 1'b0;
      end else begin
         if (take & avs_write & sel_mask & avs_byteenable[0]) begin
            mask_q <= avs_writedata[`CPSC_STAT_W-1:0];
         end
         status_q <= next_status;
         irq <= |(next_status & mask_q);
      end
   end

   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   property p_shift_in;
      disable iff (force_off)
      sclk_rise |=> shift_reg == {$past(sdata_f), $past(shift_upper)};
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("shift missed data");

   property p_hold_still;
      disable iff (force_off)
      !latch_rise |=> $stable(hold_q);
   endproperty
   a_hold_still: assert property (p_hold_still) else $error("hold moved");

   property p_latch_take;
      disable iff (force_off)
      latch_rise |=> hold_q == $past(shift_reg);
   endproperty
   a_latch_take: assert property (p_latch_take) else $error("latch lost");

   property p_outs_follow_latch;
      disable iff (force_off || force_hiz)
      latch_rise ##1 (!latch_rise && word_on)
         |=> slot_a_main_supply_out == MAIN_MAP[main_code[0]]
             && slot_b_aux_supply_out == AUX_MAP[aux_code[1]];
   endproperty
   a_outs_follow_latch: assert property (p_outs_follow_latch) else $error("bad decode");

   property p_reset_off;
      !reset_n_input |-> main_q == {`CPSC_MAIN_OFF, `CPSC_MAIN_OFF}
                         && aux_q == {`CPSC_AUX_OFF, `CPSC_AUX_OFF};
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("reset not off");

   property p_shutdown_hiz;
      reset_n_input && !shutdown_n_input |-> main_q == '0 && aux_q == '0;
   endproperty
   a_shutdown_hiz: assert property (p_shutdown_hiz) else $error("shutdown not open");

   property p_word_off;
      disable iff (force_off || force_hiz)
      !word_on [*2] |-> main_q == '0 && aux_q == '0;
   endproperty
   a_word_off: assert property (p_word_off) else $error("word off not open");

   property p_flag;
      ##1 1'b1 |-> overcurrent_flag_n_oe == |$past(overcurrent_f) && !overcurrent_flag_n_out;
   endproperty
   a_flag: assert property (p_flag) else $error("flag wrong");

   property p_limit;
      ##1 1'b1 |-> current_limit == $past(overcurrent_f);
   endproperty
   a_limit: assert property (p_limit) else $error("limit wrong");

   property p_main_levels;
      $onehot0(main_q[0]) && $onehot0(main_q[1]);
   endproperty
   a_main_levels: assert property (p_main_levels) else $error("main short");

   property p_aux_levels;
      $onehot0(aux_q[0]) && $onehot0(aux_q[1]);
   endproperty
   a_aux_levels: assert property (p_aux_levels) else $error("aux short");

   property p_float_latch;
      !serial_latch_driven [*4] |-> !latch_rise;
   endproperty
   a_float_latch: assert property (p_float_latch) else $error("float latched");

   property p_width;
      disable iff (force_off)
      sclk_rise |=> shift_reg[`CPSC_WORD_W-1] == $past(sdata_f);
   endproperty
   a_width: assert property (p_width) else $error("word width");

   property p_bus_answer;
      req && wait_q |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

   c_latch: cover property (latch_rise ##2 word_on);
   c_shutdown: cover property (force_hiz && reset_n_input);
   c_overcurrent: cover property (overcurrent_flag_n_oe);
   c_irq: cover property (irq ##[1:20] !irq);

endmodule
`default_nettype wire

// ### hdl/cpsc_defs.svh
/*
 constants of the card power serial control block: word layout, decode
 codes, switch bit positions, register map, status bits and reset values.
 assumes it is included by bare name from the package and the top module.
*/
`ifndef CPSC_DEFS_SVH
`define CPSC_DEFS_SVH

// control word
`define CPSC_WORD_W 11
`define CPSC_SHUTDOWN_BIT 8
`define CPSC_WORD_RST 11'h100
`define CPSC_A_MAIN_LSB 0
`define CPSC_A_AUX_LSB 2
`define CPSC_B_MAIN_LSB 5
`define CPSC_B_AUX_LO 7
`define CPSC_B_AUX_HI_LSB 9

// switch bit positions, all zero means high impedance
`define CPSC_SW_DIS 0
`define CPSC_MAIN_SW_33 1
`define CPSC_MAIN_SW_50 2
`define CPSC_AUX_SW_18 1
`define CPSC_AUX_SW_33 2
`define CPSC_AUX_SW_50 3
`define CPSC_MAIN_OFF 3'h1
`define CPSC_AUX_OFF 4'h1

// input synchroniser lanes
`define CPSC_SYNC_N 9
`define CPSC_SYNC_INIT 9'h018
`define CPSC_IN_SCLK 0
`define CPSC_IN_SDATA 1
`define CPSC_IN_LATCH 2
`define CPSC_IN_SHUTDOWN_N 3
`define CPSC_IN_RST_N 4
`define CPSC_IN_OVC_LSB 5

// register map, byte addresses
`define CPSC_ADDR_W 4
`define CPSC_REG_STATUS 4'h0
`define CPSC_REG_MASK 4'h4
`define CPSC_REG_WORD 4'h8
`define CPSC_REG_OUTS 4'hC
`define CPSC_STAT_W 7
`define CPSC_STAT_OVC_LSB 0
`define CPSC_STAT_LATCH 4
`define CPSC_STAT_SHUTDOWN 5
`define CPSC_STAT_RESET 6
`define CPSC_MASK_RST 7'h00
`define CPSC_WORD_SHIFT_LSB 16
`define CPSC_OUTS_OVC_LSB 16

`endif

// ### hdl/cpsc_pkg.sv
/*
 types of the card power serial control block.
 assumes cpsc_defs.svh is on the include path.
*/
`include "cpsc_defs.svh"

package cpsc_pkg;
   typedef logic [`CPSC_WORD_W-1:0] cpsc_word_t;
   typedef logic [2:0] cpsc_main_sw_t;
   typedef logic [3:0] cpsc_aux_sw_t;
   typedef logic [`CPSC_STAT_W-1:0] cpsc_stat_t;
endpackage

// ### tb/cpsc_ctrl_model.sv
/*
 model of the card socket controller: shifts an eleven bit word out on the
 serial clock and data lines, then pulses the latch, or leaves it floating.
 assumes the bench calls send from one process at a time.
*/
`timescale 1ns/100ps
`default_nettype none

module cpsc_ctrl_model (
   input wire logic ref_clk,
   output logic serial_clk_in,
   output logic serial_data_in,
   output logic serial_latch_in,
   output logic serial_latch_driven
);
   initial begin
      serial_clk_in = 1'b0;
      serial_data_in = 1'b0;
      serial_latch_in = 1'b0;
      serial_latch_driven = 1'b1;
   end

   // serial clock stands still between frames, 80 ns period inside one
   task automatic send(input cpsc_pkg::cpsc_word_t w, input logic float_latch);
      for (int i = 0; i < 11; i++) begin
         @(posedge ref_clk);
         serial_data_in <= w[i];
         repeat (3) @(posedge ref_clk);
         serial_clk_in <= 1'b1;
         repeat (4) @(posedge ref_clk);
         serial_clk_in <= 1'b0;
      end
      @(posedge ref_clk);
      // data line no longer valid: show the inverse so stale data cannot pass
      serial_data_in <= ~w[10];
      // a floating latch still wiggles here; the pad must ignore it
      serial_latch_driven <= !float_latch;
      serial_latch_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      serial_latch_in <= 1'b0;
      @(posedge ref_clk);
      serial_latch_driven <= 1'b1;
   endtask
endmodule

`default_nettype wire

// ### tb/tb.sv
/*
 self-checking bench of the card power serial control block.
 assumes the controller model and the design files are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cpsc_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("unexpected at %0t: got %h want %h", $time, g, e); end end

module tb;
   localparam logic [14:0] OFF = {4'h1, 3'h1, 1'b0, 4'h1, 3'h1};
   logic ref_clk, rst, reset_n_input, shutdown_n_input, irq;
   logic serial_clk_in, serial_data_in, serial_latch_in, serial_latch_driven;
   logic avs_read, avs_write, avs_waitrequest, overcurrent_flag_n_out, overcurrent_flag_n_oe;
   logic [3:0] overcurrent_sense, current_limit, avs_byteenable, avs_address, a_aux, b_aux;
   logic [2:0] a_main, b_main;
   logic [31:0] avs_writedata, avs_readdata, rd;
   cpsc_pkg::cpsc_word_t w;
   int bad_count, comparisons;

   cpsc_top dut (.ref_clk(ref_clk), .rst(rst), .serial_clk_in(serial_clk_in),
      .serial_data_in(serial_data_in), .serial_latch_in(serial_latch_in),
      .serial_latch_driven(serial_latch_driven), .reset_n_input(reset_n_input),
      .shutdown_n_input(shutdown_n_input), .overcurrent_sense(overcurrent_sense),
      .slot_a_main_supply_out(a_main), .slot_a_aux_supply_out(a_aux),
      .slot_b_main_supply_out(b_main), .slot_b_aux_supply_out(b_aux),
      .current_limit(current_limit),
      .overcurrent_flag_n_out(overcurrent_flag_n_out),
      .overcurrent_flag_n_oe(overcurrent_flag_n_oe), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq));

   cpsc_ctrl_model ctrl (.ref_clk(ref_clk), .serial_clk_in(serial_clk_in),
      .serial_data_in(serial_data_in), .serial_latch_in(serial_latch_in),
      .serial_latch_driven(serial_latch_driven));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // supply enables in the same packing as the outputs register
   function automatic logic [14:0] exp_out(input cpsc_pkg::cpsc_word_t x);
      logic [2:0] am, bm;
      logic [3:0] aa, ba;
      am = (x[1:0] == 2'h3) ? 3'h0 : 3'h1 << x[1:0];
      bm = (x[6:5] == 2'h3) ? 3'h0 : 3'h1 << x[6:5];
      aa = x[4] ? 4'h0 : 4'h1 << x[3:2];
      ba = x[10] ? 4'h0 : 4'h1 << {x[9], x[7]};
      return x[8] ? {ba, bm, 1'b0, aa, am} : 15'h0000;
   endfunction

   function automatic cpsc_pkg::cpsc_word_t mk(input logic [2:0] c, input logic d8);
      logic [2:0] b;
      b = 3'h4 - c;
      return {b[2:1], d8, b[0], ~c[1:0], c, c[1:0]};
   endfunction

   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      // no local limit: a missing answer is left to the watchdog
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic ow(input logic [14:0] e);
      `CHK({b_aux, b_main, 1'b0, a_aux, a_main}, e)
   endtask

   task automatic send(input cpsc_pkg::cpsc_word_t x, input logic fl);
      ctrl.send(x, fl);
      repeat (12) @(posedge ref_clk);
   endtask

   task automatic print_verdict;
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      #300000;
      bad_count++;
      print_verdict;
   end

   initial begin
      rst = 1'b1;
      reset_n_input = 1'b1;
      shutdown_n_input = 1'b1;
      overcurrent_sense = 4'h0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      bad_count = 0;
      comparisons = 0;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      ow(OFF);
      bus(1'b0, `CPSC_REG_MASK, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      bus(1'b0, `CPSC_REG_STATUS, 32'h0000_0000);
      bus(1'b1, `CPSC_REG_MASK, 32'h0000_0010);
      // every main code, aux codes 0 to 4, plus a word with the shutdown bit clear
      for (int i = 0; i < 6; i++) begin
         w = mk(3'(i), i != 5);
         send(w, 1'b0);
         ow(exp_out(w));
         `CHK(irq, 1'b1)
         bus(1'b0, `CPSC_REG_STATUS, 32'h0000_0000);
         `CHK(rd[4], 1'b1)
         repeat (2) @(posedge ref_clk);
         `CHK(irq, 1'b0)
      end
      w = 11'h1E4;
      send(w, 1'b0);
      send(11'h0A5, 1'b1);
      ow(exp_out(w));
      bus(1'b0, `CPSC_REG_OUTS, 32'h0000_0000);
      `CHK(rd, {17'h0_0000, exp_out(w)})
      bus(1'b0, `CPSC_REG_WORD, 32'h0000_0000);
      `CHK(rd, {5'h00, 11'h0A5, 5'h00, w})
      @(posedge ref_clk);
      shutdown_n_input <= 1'b0;
      #1;
      ow(15'h0000);
      repeat (3) @(posedge ref_clk);
      shutdown_n_input <= 1'b1;
      repeat (12) @(posedge ref_clk);
      ow(exp_out(w));
      reset_n_input <= 1'b0;
      #1;
      ow(OFF);
      repeat (3) @(posedge ref_clk);
      reset_n_input <= 1'b1;
      repeat (12) @(posedge ref_clk);
      ow(OFF);
      bus(1'b0, `CPSC_REG_WORD, 32'h0000_0000);
      `CHK(rd[10:0], 11'h100)
      bus(1'b0, `CPSC_REG_STATUS, 32'h0000_0000);
      for (int j = 0; j < 4; j++) begin
         overcurrent_sense <= 4'h1 << j;
         repeat (8) @(posedge ref_clk);
         `CHK(current_limit, 4'h1 << j)
         `CHK(overcurrent_flag_n_oe, 1'b1)
         `CHK(overcurrent_flag_n_out, 1'b0)
         `CHK(irq, 1'b0)
         overcurrent_sense <= 4'h0;
         repeat (8) @(posedge ref_clk);
         `CHK({overcurrent_flag_n_oe, current_limit}, 5'h00)
      end
      bus(1'b0, `CPSC_REG_STATUS, 32'h0000_0000);
      `CHK(rd[3:0], 4'hF)
      bus(1'b1, `CPSC_REG_MASK, 32'h0000_0001);
      overcurrent_sense <= 4'h1;
      repeat (8) @(posedge ref_clk);
      `CHK(irq, 1'b1)
      overcurrent_sense <= 4'h0;
      bus(1'b0, `CPSC_REG_STATUS, 32'h0000_0000);
      repeat (2) @(posedge ref_clk);
      `CHK(irq, 1'b0)
      // unmapped place: write ignored, read gives zero
      bus(1'b1, 4'h2, 32'hFFFF_FFFF);
      bus(1'b0, 4'h2, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      print_verdict;
   end
endmodule

`default_nettype wire
